// file: rtl/pse_irq_pkg.sv
package pse_irq_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_IRQ_SUMMARY       = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK          = 8'h01;
  localparam logic [7:0] ADDR_POWER_EVENT       = 8'h02;
  localparam logic [7:0] ADDR_POWER_EVENT_CLR   = 8'h03;
  localparam logic [7:0] ADDR_PROBE_EVENT       = 8'h04;
  localparam logic [7:0] ADDR_PROBE_EVENT_CLR   = 8'h05;
  localparam logic [7:0] ADDR_FAULT_EVENT       = 8'h06;
  localparam logic [7:0] ADDR_FAULT_EVENT_CLR   = 8'h07;
  localparam logic [7:0] ADDR_STARTUP_EVENT     = 8'h08;
  localparam logic [7:0] ADDR_STARTUP_EVENT_CLR = 8'h09;
  localparam logic [7:0] ADDR_SUPPLY_EVENT      = 8'h0a;
  localparam logic [7:0] ADDR_SUPPLY_EVENT_CLR  = 8'h0b;
  localparam logic [5:0] ADDR_PORT_RESULT_BLK   = 6'h03;
  localparam logic [7:0] ADDR_POWER_STATE       = 8'h10;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] IRQ_MASK_RESET     = 8'h00;
  localparam logic [7:0] EVENT_RESET        = 8'h00;
  localparam logic [7:0] PORT_RESULT_RESET  = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SUM_ON_OFF        = 0;
  localparam int SUM_GOOD          = 1;
  localparam int SUM_CUTOFF        = 2;
  localparam int SUM_PROBE         = 3;
  localparam int SUM_CLASS         = 4;
  localparam int SUM_UNPLUG        = 5;
  localparam int SUM_STARTUP       = 6;
  localparam int SUM_SUPPLY        = 7;
  localparam int SUPPLY_MAIN_UV    = 4;
  localparam int SUPPLY_LOGIC_UV   = 5;
  localparam int SUPPLY_OVER_TEMP  = 7;
  localparam int NUM_PORTS         = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ                = 100;
  localparam int OVERLOAD_CUTOFF_US     = 60;
  localparam int UNPLUG_WINDOW_US       = 300;
  localparam int OVERLOAD_CUTOFF_CYCLES = OVERLOAD_CUTOFF_US * CLK_MHZ;
  localparam int UNPLUG_WINDOW_CYCLES   = UNPLUG_WINDOW_US * CLK_MHZ;

endpackage

// file: rtl/sticky_event_reg.sv
module sticky_event_reg #(
  parameter int         WIDTH = 8,
  parameter logic [7:0] INIT  = 8'h00
) (
  input  wire  logic             sys_clk,
  input  wire  logic             rst,
  input  wire  logic [WIDTH-1:0] set,
  input  wire  logic             clr,
  output logic       [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] next_flags;

  // set wins over a clear in the same cycle, so no event is lost
  assign next_flags = (flags & ~{WIDTH{clr}}) | set;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags <= INIT[WIDTH-1:0];
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// file: rtl/quad_port_event_interrupt.sv
// Operation
// (RL1) summary bits 0,1 from power event halves
// (RL2) summary bits 2,5 from fault event halves
// (RL3) summary bits 3,4 from probe/class halves
// (RL4) summary bits 6,7 from start-up, supply
// (RL5) summary read-only, pure mirror, no storage
// (RL6) mask enables groups, active-low interrupt pulled
// (RL7) interrupt released when no enabled group active
// (RL8) power event: on/off low, good-change high
// (RL9) power-good change sets good_change flag
// (RL10) clear mirror reads same as base
// (RL11) mirror read clears base and mirror
// (RL12) flags sticky; base read never clears
// (RL13) probe low nibble, class high nibble
// (RL14) per-port result registers at 0ch-0fh
// (RL15) overload cutoff sets fault bits 0-3
// (RL16) unplug timeout sets fault bits 4-7
// (RL17) five event registers feed summary
// (RL18) start-up: inrush low, current-limit high
// (RL19) supply bits 4,5,7; rest reserved
//
// Local design decision: the plain strobed port.
module quad_port_event_interrupt
  import pse_irq_pkg::*;
#(
  parameter int CUTOFF_CYCLES = OVERLOAD_CUTOFF_CYCLES,
  parameter int UNPLUG_CYCLES = UNPLUG_WINDOW_CYCLES,
  parameter int TIMER_W       = 16
) (
  input  wire  logic        sys_clk,
  input  wire  logic        rst,
  input  wire  logic [7:0]  addr,
  input  wire  logic [7:0]  wdata,
  input  wire  logic        wr_en,
  input  wire  logic        rd_en,
  output logic       [7:0]  rdata,
  output logic              irq_n,
  input  wire  logic [3:0]  port_on,
  input  wire  logic [3:0]  power_good,
  input  wire  logic [3:0]  probe_done,
  input  wire  logic [3:0]  class_done,
  input  wire  logic [3:0]  port_result_load,
  input  wire  logic [31:0] port_result_value,
  input  wire  logic [3:0]  overload_threshold,
  input  wire  logic [3:0]  under_unplug,
  input  wire  logic [3:0]  inrush_timeout,
  input  wire  logic [3:0]  limit_timeout,
  input  wire  logic        main_uv,
  input  wire  logic        logic_uv,
  input  wire  logic        over_temp,
  output logic       [3:0]  port_cutoff
);

  localparam logic [TIMER_W-1:0] CUT_LAST    = TIMER_W'(CUTOFF_CYCLES - 1);
  localparam logic [TIMER_W-1:0] CUT_DONE    = TIMER_W'(CUTOFF_CYCLES);
  localparam logic [TIMER_W-1:0] UNPLUG_LAST = TIMER_W'(UNPLUG_CYCLES - 1);
  localparam logic [TIMER_W-1:0] UNPLUG_DONE = TIMER_W'(UNPLUG_CYCLES);

  // ****************************************
  // port state tracking
  // ****************************************
  logic [3:0] on_q;
  logic [3:0] pg_q;
  logic       state_seen;
  wire  [3:0] on_change;
  wire  [3:0] good_change;

  // first cycle after reset only captures, a reset is not a change
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      on_q       <= 4'h0;
      pg_q       <= 4'h0;
      state_seen <= 1'b0;
    end else begin
      on_q       <= port_on;
      pg_q       <= power_good;
      state_seen <= 1'b1;
    end
  end

  assign on_change   = {4{state_seen}} & (port_on ^ on_q);
  assign good_change = {4{state_seen}} & (power_good ^ pg_q); // RL9

  // ****************************************
  // overload and unplug timers
  // ****************************************
  logic [TIMER_W-1:0] cut_cnt    [NUM_PORTS];
  logic [TIMER_W-1:0] unplug_cnt [NUM_PORTS];
  wire  [3:0]         cut_cond;
  wire  [3:0]         unplug_cond;
  wire  [3:0]         cut_fire;
  wire  [3:0]         unplug_fire;

  assign cut_cond    = on_q & overload_threshold;
  assign unplug_cond = on_q & under_unplug;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_timer
      // timers hold at the end value so one excursion fires once
      assign cut_fire[gi]    = cut_cond[gi] && (cut_cnt[gi] == CUT_LAST); // RL15
      assign unplug_fire[gi] = unplug_cond[gi] && (unplug_cnt[gi] == UNPLUG_LAST); // RL16

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cut_cnt[gi] <= '0;
        end else if (!cut_cond[gi]) begin
          cut_cnt[gi] <= '0;
        end else if (cut_cnt[gi] != CUT_DONE) begin
          cut_cnt[gi] <= cut_cnt[gi] + 1'b1;
        end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          unplug_cnt[gi] <= '0;
        end else if (!unplug_cond[gi]) begin
          unplug_cnt[gi] <= '0;
        end else if (unplug_cnt[gi] != UNPLUG_DONE) begin
          unplug_cnt[gi] <= unplug_cnt[gi] + 1'b1;
        end
      end
    end
  endgenerate

  // cut request to the port switch, same edge as the flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_cutoff <= 4'h0;
    end else begin
      port_cutoff <= cut_fire; // RL15
    end
  end

  // ****************************************
  // per-port result registers
  // ****************************************
  logic [7:0] port_result [NUM_PORTS];

  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_result
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          port_result[gi] <= PORT_RESULT_RESET;
        end else if (port_result_load[gi]) begin
          port_result[gi] <= port_result_value[gi*8 +: 8]; // RL14
        end
      end
    end
  endgenerate

  // ****************************************
  // address decode
  // ****************************************
  wire sel_summary   = (addr == ADDR_IRQ_SUMMARY);
  wire sel_mask      = (addr == ADDR_IRQ_MASK);
  wire sel_power     = (addr == ADDR_POWER_EVENT) || (addr == ADDR_POWER_EVENT_CLR);
  wire sel_probe     = (addr == ADDR_PROBE_EVENT) || (addr == ADDR_PROBE_EVENT_CLR);
  wire sel_fault     = (addr == ADDR_FAULT_EVENT) || (addr == ADDR_FAULT_EVENT_CLR);
  wire sel_startup   = (addr == ADDR_STARTUP_EVENT) || (addr == ADDR_STARTUP_EVENT_CLR);
  wire sel_supply    = (addr == ADDR_SUPPLY_EVENT) || (addr == ADDR_SUPPLY_EVENT_CLR);
  wire sel_result    = (addr[7:2] == ADDR_PORT_RESULT_BLK);
  wire sel_state     = (addr == ADDR_POWER_STATE);
  // only the odd mirror addresses clear; base reads are harmless
  wire clr_power     = rd_en && (addr == ADDR_POWER_EVENT_CLR); // RL11
  wire clr_probe     = rd_en && (addr == ADDR_PROBE_EVENT_CLR); // RL11
  wire clr_fault     = rd_en && (addr == ADDR_FAULT_EVENT_CLR); // RL11
  wire clr_startup   = rd_en && (addr == ADDR_STARTUP_EVENT_CLR); // RL11
  wire clr_supply    = rd_en && (addr == ADDR_SUPPLY_EVENT_CLR); // RL11

  // ****************************************
  // event registers
  // ****************************************
  logic [7:0] power_flags;
  logic [7:0] probe_flags;
  logic [7:0] fault_flags;
  logic [7:0] startup_flags;
  logic [7:0] supply_flags;
  wire  [7:0] power_set   = {good_change, on_change}; // RL8
  wire  [7:0] probe_set   = {class_done, probe_done}; // RL13
  wire  [7:0] fault_set   = {unplug_fire, cut_fire};
  wire  [7:0] startup_set = {limit_timeout, inrush_timeout}; // RL18
  // reserved supply bits never set, so they read zero
  wire  [7:0] supply_set  = {over_temp, 1'b0, logic_uv, main_uv, 4'h0}; // RL19

  // five stores, each seen at a base and a mirror address
  sticky_event_reg #(.WIDTH(8), .INIT(EVENT_RESET)) u_power (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (power_set),
    .clr     (clr_power),
    .flags   (power_flags)
  ); // RL17 RL12

  sticky_event_reg #(.WIDTH(8), .INIT(EVENT_RESET)) u_probe (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (probe_set),
    .clr     (clr_probe),
    .flags   (probe_flags)
  ); // RL17

  sticky_event_reg #(.WIDTH(8), .INIT(EVENT_RESET)) u_fault (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (fault_set),
    .clr     (clr_fault),
    .flags   (fault_flags)
  ); // RL17

  sticky_event_reg #(.WIDTH(8), .INIT(EVENT_RESET)) u_startup (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (startup_set),
    .clr     (clr_startup),
    .flags   (startup_flags)
  ); // RL17

  sticky_event_reg #(.WIDTH(8), .INIT(EVENT_RESET)) u_supply (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (supply_set),
    .clr     (clr_supply),
    .flags   (supply_flags)
  ); // RL17

  // ****************************************
  // summary, mask and interrupt
  // ****************************************
  logic [7:0] irq_mask;
  wire  [7:0] irq_summary;

  // no storage: summary follows the flags combinationally
  assign irq_summary[SUM_ON_OFF]  = |power_flags[3:0]; // RL1 RL5
  assign irq_summary[SUM_GOOD]    = |power_flags[7:4]; // RL1
  assign irq_summary[SUM_CUTOFF]  = |fault_flags[3:0]; // RL2
  assign irq_summary[SUM_PROBE]   = |probe_flags[3:0]; // RL3
  assign irq_summary[SUM_CLASS]   = |probe_flags[7:4]; // RL3
  assign irq_summary[SUM_UNPLUG]  = |fault_flags[7:4]; // RL2
  assign irq_summary[SUM_STARTUP] = |startup_flags; // RL4
  assign irq_summary[SUM_SUPPLY]  = |supply_flags; // RL4

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (wr_en && sel_mask) begin
      irq_mask <= wdata; // RL6
    end
  end

  // low while any enabled group is active, high otherwise
  assign irq_n = ~|(irq_summary & irq_mask); // RL6 RL7

  // ****************************************
  // read path
  // ****************************************
  wire [7:0] next_rdata =
    sel_summary ? irq_summary :
    sel_mask    ? irq_mask :
    sel_power   ? power_flags : // RL10
    sel_probe   ? probe_flags : // RL10
    sel_fault   ? fault_flags : // RL10
    sel_startup ? startup_flags :
    sel_supply  ? supply_flags :
    sel_result  ? port_result[addr[1:0]] :
    sel_state   ? {pg_q, on_q} :
    8'h00;

  // mirror data is taken before the clear lands, so nothing is lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_irq_level: assert property (@(posedge sys_clk) disable iff (rst) // RL6
    (wr_en && sel_mask && (wdata & irq_summary) != 8'h00) |=> !irq_n)
    else $error("interrupt not raised for an enabled active group");

  a_irq_release: assert property (@(posedge sys_clk) disable iff (rst) // RL7
    (wr_en && sel_mask && wdata == 8'h00) |=> irq_n)
    else $error("interrupt not released with all groups masked");

  a_summary_groups: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    irq_summary == {|supply_flags, |startup_flags, |fault_flags[7:4], |probe_flags[7:4],
                    |probe_flags[3:0], |fault_flags[3:0], |power_flags[7:4],
                    |power_flags[3:0]})
    else $error("summary does not follow event groups");

  a_mirror_same: assert property (@(posedge sys_clk) disable iff (rst) // RL10
    (rd_en && addr == ADDR_FAULT_EVENT_CLR) |=> rdata == $past(fault_flags))
    else $error("mirror read differs from base contents");

  a_clear_read: assert property (@(posedge sys_clk) disable iff (rst) // RL11
    (rd_en && addr == ADDR_POWER_EVENT_CLR && power_set == 8'h00) |=> power_flags == 8'h00)
    else $error("mirror read did not clear the pair");

  a_base_keeps: assert property (@(posedge sys_clk) disable iff (rst) // RL12
    (rd_en && addr == ADDR_PROBE_EVENT) |=> probe_flags == ($past(probe_flags) | $past(probe_set)))
    else $error("base read disturbed the flags");

  a_good_change: assert property (@(posedge sys_clk) disable iff (rst) // RL9
    (state_seen && power_good[0] != pg_q[0]) |=> power_flags[4])
    else $error("power-good change not flagged");

  a_cutoff_time: assert property (@(posedge sys_clk) disable iff (rst) // RL15
    (cut_cond[0] && cut_cnt[0] == CUT_LAST) |=> (fault_flags[0] && port_cutoff[0]))
    else $error("overload cutoff not flagged at the end of the cutoff time");

  a_unplug_time: assert property (@(posedge sys_clk) disable iff (rst) // RL16
    (unplug_cond[1] && unplug_cnt[1] == UNPLUG_LAST) |=> fault_flags[5])
    else $error("unplug timeout not flagged");

  a_result_load: assert property (@(posedge sys_clk) disable iff (rst) // RL14
    port_result_load[2] |=> port_result[2] == $past(port_result_value[23:16]))
    else $error("port result not stored");

  a_supply_reserved: assert property (@(posedge sys_clk) disable iff (rst) // RL19
    supply_flags[3:0] == 4'h0 && !supply_flags[6])
    else $error("reserved supply bit set");

  a_mask_write: assert property (@(posedge sys_clk) disable iff (rst) // RL6
    (wr_en && sel_mask) |=> irq_mask == $past(wdata))
    else $error("mask write not stored");

  a_set_wins: assert property (@(posedge sys_clk) disable iff (rst) // RL11
    (rd_en && addr == ADDR_PROBE_EVENT_CLR) |=> probe_flags == $past(probe_set))
    else $error("mirror read left stale flags or lost a new event");

  a_power_map: assert property (@(posedge sys_clk) disable iff (rst) // RL8
    (state_seen && port_on[2] != on_q[2]) |=> power_flags[2])
    else $error("on/off change not flagged");

  a_probe_map: assert property (@(posedge sys_clk) disable iff (rst) // RL13
    class_done[3] |=> probe_flags[7])
    else $error("classification finish not flagged");

  a_startup_map: assert property (@(posedge sys_clk) disable iff (rst) // RL18
    limit_timeout[1] |=> (startup_flags[5] && irq_summary[SUM_STARTUP]))
    else $error("current-limit timeout not flagged");

endmodule

// file: dv/host_model.sv
module host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_en,
  output logic            rd_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // host side of the register bus
  // ****************************************
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // one idle edge between strobes, so no strobe is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

// file: dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pse_irq_pkg::*;

  logic        sys_clk, rst, wr_en, rd_en, irq_n, main_uv, logic_uv, over_temp;
  logic [7:0]  addr, wdata, rdata, mask, d;
  logic [3:0]  port_on, power_good, probe_done, class_done, port_result_load;
  logic [3:0]  overload_threshold, under_unplug, inrush_timeout, limit_timeout, port_cutoff;
  logic [31:0] port_result_value, seed;
  logic [7:0]  ev [5];
  int          error_cnt, tests_run, k, hits, first;

  // ****************************************
  // clock, design and host
  // ****************************************
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // short counts keep the timer scenarios brief
  quad_port_event_interrupt #(.CUTOFF_CYCLES(5), .UNPLUG_CYCLES(8)) u_dut (
    .sys_clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq_n, .port_on, .power_good,
    .probe_done, .class_done, .port_result_load, .port_result_value, .overload_threshold,
    .under_unplug, .inrush_timeout, .limit_timeout, .main_uv, .logic_uv, .over_temp,
    .port_cutoff);
  host_model u_host (.sys_clk, .rdata, .addr, .wdata, .wr_en, .rd_en);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] nx(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [7:0] summ();
    return {|ev[4], |ev[3], |ev[2][7:4], |ev[1][7:4], |ev[1][3:0], |ev[2][3:0],
            |ev[0][7:4], |ev[0][3:0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check_all(input bit clear);
    u_host.rd(ADDR_IRQ_SUMMARY, d);
    chk(d, summ(), "summary");
    chk({7'h00, irq_n}, {7'h00, ~|(summ() & mask)}, "irq");
    for (int i = 0; i < 5; i++) begin
      u_host.rd(ADDR_POWER_EVENT + 8'(2 * i), d);
      chk(d, ev[i], "event");
    end
    if (clear) begin
      for (int i = 0; i < 5; i++) begin
        u_host.rd(ADDR_POWER_EVENT_CLR + 8'(2 * i), d);
        chk(d, ev[i], "mirror");
        ev[i] = 8'h00;
      end
    end
  endtask

  // pulses last one cycle; level inputs toggle by the random bits
  task automatic ev_round();
    seed = nx(seed);
    @(posedge sys_clk);
    probe_done     <= seed[3:0];
    class_done     <= seed[7:4];
    inrush_timeout <= seed[11:8];
    limit_timeout  <= seed[15:12];
    {main_uv, logic_uv, over_temp} <= seed[18:16];
    port_on    <= port_on ^ seed[22:19];
    power_good <= power_good ^ seed[26:23];
    ev[0] = ev[0] | {seed[26:23], seed[22:19]};
    ev[1] = ev[1] | seed[7:0];
    ev[3] = ev[3] | seed[15:8];
    ev[4] = ev[4] | {seed[16], 1'b0, seed[17], seed[18], 4'h0};
    @(posedge sys_clk);
    {probe_done, class_done, inrush_timeout, limit_timeout} <= 16'h0000;
    {main_uv, logic_uv, over_temp} <= 3'h0;
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("Error %0t: watchdog expired", $time);
    finish_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {port_on, power_good, probe_done, class_done, port_result_load} = 20'h00000;
    {overload_threshold, under_unplug, inrush_timeout, limit_timeout} = 16'h0000;
    {main_uv, logic_uv, over_temp} = 3'h0;
    port_result_value = 32'h00000000;
    seed = 32'hea22;
    mask = 8'h00;
    error_cnt = 0;
    tests_run = 0;
    for (int i = 0; i < 5; i++) ev[i] = 8'h00;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    u_host.rd(ADDR_IRQ_MASK, d);
    chk(d, IRQ_MASK_RESET, "mask reset");
    check_all(0);
    u_host.rd(8'h20, d);
    chk(d, 8'h00, "unmapped");
    $display("test reset done");

    for (k = 0; k < 40; k++) begin
      ev_round();
      if (k % 8 == 7) begin
        seed = nx(seed);
        mask = seed[7:0];
        u_host.wr(ADDR_IRQ_MASK, mask);
        u_host.wr(ADDR_POWER_EVENT, 8'hff);
        u_host.wr(ADDR_IRQ_SUMMARY, 8'hff);
        u_host.rd(ADDR_IRQ_MASK, d);
        chk(d, mask, "mask");
        check_all(0);
        check_all(k > 20);
      end
    end
    check_all(1);
    check_all(0);
    $display("test random events done");

    // overload and unplug need the ports powered for a while first
    @(posedge sys_clk);
    ev[0] = {4'h0, port_on ^ 4'hf};
    port_on <= 4'hf;
    mask = 8'h24;
    u_host.wr(ADDR_IRQ_MASK, mask);
    check_all(1);
    @(posedge sys_clk);
    overload_threshold <= 4'h1;
    hits = 0;
    first = 0;
    for (k = 1; k <= 15; k++) begin
      @(posedge sys_clk);
      #1;
      if (port_cutoff !== 4'h0) begin
        hits++;
        if (first == 0) first = k;
        chk({4'h0, port_cutoff}, 8'h01, "cutoff port");
      end
    end
    chk(8'(first), 8'h05, "cutoff delay");
    chk(8'(hits), 8'h01, "cutoff pulses");
    ev[2] = 8'h01;
    @(posedge sys_clk);
    overload_threshold <= 4'h0;
    under_unplug <= 4'h2;
    repeat (7) @(posedge sys_clk);
    under_unplug <= 4'h0;
    u_host.rd(ADDR_FAULT_EVENT, d);
    chk(d, 8'h01, "unplug early");
    @(posedge sys_clk);
    under_unplug <= 4'h2;
    repeat (8) @(posedge sys_clk);
    under_unplug <= 4'h0;
    ev[2] = 8'h21;
    check_all(0);
    check_all(1);
    check_all(0);
    $display("test overload unplug done");

    seed = nx(seed);
    @(posedge sys_clk);
    port_result_value <= seed;
    port_result_load  <= 4'hf;
    @(posedge sys_clk);
    port_result_load  <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      u_host.rd(8'h0c + 8'(i), d);
      chk(d, seed[8 * i +: 8], "port result");
    end
    u_host.rd(ADDR_POWER_STATE, d);
    chk(d, {power_good, port_on}, "power state");
    $display("test port result done");

    // an enabled group pulls the pin, masking it off must let go
    @(posedge sys_clk);
    over_temp <= 1'b1;
    @(posedge sys_clk);
    over_temp <= 1'b0;
    ev[4] = 8'h80;
    mask = 8'h80;
    u_host.wr(ADDR_IRQ_MASK, mask);
    check_all(0);
    mask = 8'h00;
    u_host.wr(ADDR_IRQ_MASK, mask);
    check_all(1);
    $display("test irq release done");
    finish_test();
  end
endmodule
